/* hw/dri_pkg.sv */
// dri_pkg: constants, register map and states of the dram init controller
// assumes a 125 MHz system clock; all waits are counted in its cycles
package dri_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and waits
	localparam int unsigned CLK_PS        = 8000;
	localparam int unsigned T_PW_RESET_NS = 1000;
	localparam int unsigned PW_CYC        = (T_PW_RESET_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned T_POST_RST_US = 500;
	localparam int unsigned POST_RST_CYC  = (T_POST_RST_US * 1000000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned T_CK_STB_NS   = 10;
	localparam int unsigned CK_STB_TCK    = 5;
	localparam int unsigned CK_STB_NS_CYC = (T_CK_STB_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned CK_STB_CYC    = (CK_STB_NS_CYC > CK_STB_TCK) ?
	                                        CK_STB_NS_CYC : CK_STB_TCK;
	localparam int unsigned T_XS_NS       = 360;
	localparam int unsigned XPR_TCK       = 5;
	localparam int unsigned XS_CYC        = (T_XS_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned XPR_CYC       = (XS_CYC > XPR_TCK) ? XS_CYC : XPR_TCK;
	localparam longint unsigned T_KEEP_MS = 960;
	localparam int unsigned KEEPALIVE_CYC = 32'(T_KEEP_MS * 1000000000 / CLK_PS);

	////////////////////////////////////////////////////////////////////////
	// register map (byte offsets) and field positions
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TIMA = 8'h08;
	localparam logic [7:0] A_TIMB = 8'h0C;
	localparam logic [7:0] A_CMD  = 8'h10;
	localparam logic [7:0] A_MR0  = 8'h20;
	localparam int unsigned MR_NUM     = 7;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned SB_DONE    = 0;
	localparam int unsigned SB_BUSY    = 1;
	localparam int unsigned SB_ALERT   = 2;
	localparam int unsigned SB_RPR     = 3;
	localparam int unsigned SB_REFUSED = 4;
	localparam int unsigned TA_MRD     = 0;
	localparam int unsigned TA_MOD     = 8;
	localparam int unsigned TA_XPR     = 16;
	localparam int unsigned TB_DLLK    = 0;
	localparam int unsigned TB_ZQI     = 16;
	localparam int unsigned CF_BA      = 18;
	localparam int unsigned CF_BG      = 20;
	localparam int unsigned CF_OP      = 22;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0]  TMRD_RST  = 8'h08;
	localparam logic [7:0]  TMOD_RST  = 8'h18;
	localparam logic [7:0]  TXPR_RST  = 8'(XPR_CYC);
	localparam logic [15:0] TDLLK_RST = 16'h0400;
	localparam logic [15:0] TZQI_RST  = 16'h0400;

	////////////////////////////////////////////////////////////////////////
	// command codes {cs_n, act_n, ras_n, cas_n, we_n}
	localparam logic [4:0]  CMD_DES  = 5'h1F;
	localparam logic [4:0]  CMD_MRS  = 5'h08;
	localparam logic [4:0]  CMD_ZQCL = 5'h0E;
	localparam logic [4:0]  CMD_REF  = 5'h09;
	localparam logic [17:0] ZQ_ADDR  = 18'h0_0400;

	typedef enum logic [3:0] {
		S_IDLE, S_RST_HOLD, S_POST_RST, S_CLK_STB, S_CKE_XPR, S_MRS, S_MRS_WAIT,
		S_ZQCL, S_ZQ_WAIT, S_READY, S_REPAIR, S_RPR_MR0, S_RPR_WAIT
	} dri_state_t;

endpackage

/* hw/dri_wait_timer.sv */
// dri_wait_timer: down counter that times every wait of the sequencer
// assumes load_i is a one-cycle pulse given the cycle before the wait starts
`timescale 1ns/1ps
module dri_wait_timer (
	// system
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// control
	input  wire logic        load_i,
	input  wire logic [31:0] count_i,
	output logic             done_o
);

	logic [31:0] cnt;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 32'h0000_0000;
		end else if (load_i) begin
			cnt <= count_i;
		end else if (cnt != 32'h0000_0000) begin
			cnt <= cnt - 32'h0000_0001;
		end
	end

	assign done_o = (cnt == 32'h0000_0000);

endmodule

/* hw/dri_idle_keeper.sv */
// dri_idle_keeper: asks for a refresh when the link has been idle a full period
// assumes kick_i is high in every cycle that a command goes out
`timescale 1ns/1ps
module dri_idle_keeper #(
	parameter int unsigned PERIOD = 1000
) (
	// system
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control
	input  wire logic en_i,
	input  wire logic kick_i,
	output logic      req_o
);

	logic [31:0] cnt;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt   <= 32'h0000_0000;
			req_o <= 1'b0;
		end else begin
			req_o <= 1'b0;
			if (kick_i || !en_i) begin
				cnt <= 32'h0000_0000;
			end else if (cnt == PERIOD - 1) begin
				cnt   <= 32'h0000_0000;
				req_o <= 1'b1;
			end else begin
				cnt <= cnt + 32'h0000_0001;
			end
		end
	end

endmodule

/* hw/dri_init_ctrl.sv */
// dri_init_ctrl: dram reset and power-up sequencer, host side, with ahb-lite registers
// assumes one 125 MHz clock that also runs the dram clock; pins are synchronous
//
// What the document requires
// [R1] wait 500us after reset release before cke
// [R2] device self-initializes during that wait
// [R3] program every mode register, never trust defaults
// [R4] clock stable max(10ns, 5 tck) before cke
// [R5] deselect on the bus as cke rises
// [R6] cke stays high until init completes
// [R7] device odt high-z until cke high
// [R8] odt held low and static during init
// [R9] wait txpr after cke before first mrs
// [R10] load mr3,6,5,4,2,1 then mr0, with gaps
// [R11] dll enable in mr1 before mr0 reset
// [R12] zq long calibration, then dll lock and zqinit
// [R13] deselects fill gaps between init commands
// [R14] every defined mode register gets an mrs
// [R15] refresh before 960ms of idle
// [R16] repair entry via mr4 a0, alert low
// [R17] after alert high, rewrite saved mr0
// [R18] warm reset: hold reset, cke low first
// [R19] device clears counters except refresh
// [R20] supply change means full dll and zq redo
// [R21] bank inputs select mr, never 111
// [R22] ras, cas, we low for mrs
// [R23] tmod after mrs before other commands
// [R24] every wait timed by a loaded counter
// [R25] done flag only after both final waits
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module dri_init_ctrl
	import dri_pkg::*;
#(
	parameter int unsigned POST_CYC = POST_RST_CYC,
	parameter int unsigned KEEP_CYC = KEEPALIVE_CYC
) (
	// system
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic [31:0]      hrdata_o,
	// dram pins
	output logic             reset_n_o,
	output logic             ck_en_o,
	output logic             cke_o,
	output logic             odt_o,
	output logic             cs_n_o,
	output logic             act_n_o,
	output logic             ras_n_o,
	output logic             cas_n_o,
	output logic             we_n_o,
	output logic [1:0]       bg_o,
	output logic [1:0]       ba_o,
	output logic [17:0]      addr_o,
	input  wire logic        alert_n_i,
	// status
	output logic             init_done_o
);

	dri_state_t  state;
	dri_state_t  next_state;
	logic        tim_load;
	logic [31:0] tim_cnt;
	logic        tim_done;
	logic [2:0]  mr_step;
	logic [17:0] mr_val [MR_NUM];
	logic [23:0] tim_a;
	logic [31:0] tim_b;
	logic        start_go;
	logic        ucmd_go;
	logic [25:0] ucmd;
	logic        repair_seen;
	logic        cmd_refused;
	logic        ref_req;
	logic        ref_pend;
	logic [4:0]  cmd;
	logic        dph_wr;
	logic [7:0]  dph_addr;
	logic [31:0] rd_word;
	logic        busy;
	logic [15:0] zq_wait;

	assign busy    = !(state inside {S_IDLE, S_READY, S_REPAIR, S_RPR_MR0, S_RPR_WAIT});
	assign zq_wait = (tim_b[TB_DLLK+:16] > tim_b[TB_ZQI+:16]) ?
	                 tim_b[TB_DLLK+:16] : tim_b[TB_ZQI+:16];

	function automatic logic [2:0] mr_sel(input logic [2:0] step);
		case (step)
			3'h0: mr_sel = 3'h3;
			3'h1: mr_sel = 3'h6;
			3'h2: mr_sel = 3'h5;
			3'h3: mr_sel = 3'h4;
			3'h4: mr_sel = 3'h2;
			3'h5: mr_sel = 3'h1;
			default: mr_sel = 3'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: zero wait, always okay
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dph_wr      <= 1'b0;
			dph_addr    <= 8'h00;
			hrdata_o    <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			dph_wr <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
			if (hsel_i && htrans_i[1] && hready_i) begin
				dph_addr <= haddr_i[7:0];
			end
			if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
				hrdata_o <= rd_word;
			end
		end
	end

	// only the low byte decodes, so the map repeats every 256 bytes
	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr_i[7:0])
			A_STAT: rd_word = {27'h000_0000, cmd_refused, repair_seen, alert_n_i,
			                   busy, init_done_o};
			A_TIMA: rd_word = {8'h00, tim_a};
			A_TIMB: rd_word = tim_b;
			default: begin
				if (haddr_i[7:5] == A_MR0[7:5] && haddr_i[4:2] != 3'h7 &&
				    haddr_i[1:0] == 2'h0) begin
					rd_word = {14'h0000, mr_val[haddr_i[4:2]]};
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tim_a <= {TXPR_RST, TMOD_RST, TMRD_RST};
			tim_b <= {TZQI_RST, TDLLK_RST};
		end else if (dph_wr && dph_addr == A_TIMA) begin
			tim_a <= hwdata_i[23:0];
		end else if (dph_wr && dph_addr == A_TIMB) begin
			tim_b <= hwdata_i;
		end
	end

	// mode register images; all seven are sent on every init
	genvar gi;
	generate
		for (gi = 0; gi < MR_NUM; gi++) begin : g_mr
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					mr_val[gi] <= 18'h0_0000;
				end else if (dph_wr && dph_addr == A_MR0 + 8'(gi * 4)) begin
					mr_val[gi] <= hwdata_i[17:0]; // see [R3] [R14]
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_go <= 1'b0;
			ucmd_go  <= 1'b0;
			ucmd     <= 26'h000_0000;
		end else begin
			start_go <= dph_wr && dph_addr == A_CTRL && hwdata_i[CTRL_START];
			ucmd_go  <= dph_wr && dph_addr == A_CMD && state == S_READY; // see [R25]
			if (dph_wr && dph_addr == A_CMD) begin
				ucmd <= hwdata_i[25:0];
			end
		end
	end

	// sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			repair_seen <= 1'b0;
			cmd_refused <= 1'b0;
		end else begin
			if (state == S_READY && !alert_n_i) begin
				repair_seen <= 1'b1;
			end else if (dph_wr && dph_addr == A_STAT && hwdata_i[SB_RPR]) begin
				repair_seen <= 1'b0;
			end
			if (dph_wr && dph_addr == A_CMD && state != S_READY) begin
				cmd_refused <= 1'b1;
			end else if (dph_wr && dph_addr == A_STAT && hwdata_i[SB_REFUSED]) begin
				cmd_refused <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE:     next_state = state;
			S_RST_HOLD: if (tim_done) next_state = S_POST_RST;
			S_POST_RST: if (tim_done) next_state = S_CLK_STB; // see [R1] [R2]
			S_CLK_STB:  if (tim_done) next_state = S_CKE_XPR; // see [R4]
			S_CKE_XPR:  if (tim_done) next_state = S_MRS; // see [R9]
			S_MRS:      next_state = S_MRS_WAIT;
			S_MRS_WAIT: begin
				if (tim_done) begin
					next_state = (mr_step == 3'h7) ? S_ZQCL : S_MRS; // see [R10]
				end
			end
			S_ZQCL:     next_state = S_ZQ_WAIT;
			S_ZQ_WAIT:  if (tim_done) next_state = S_READY; // see [R12] [R25]
			S_READY:    if (!alert_n_i) next_state = S_REPAIR; // see [R16]
			S_REPAIR:   if (alert_n_i) next_state = S_RPR_MR0;
			S_RPR_MR0:  next_state = S_RPR_WAIT;
			S_RPR_WAIT: if (tim_done) next_state = S_READY;
			default:    next_state = S_IDLE;
		endcase
		// a restart also redoes dll reset and zq after a supply change
		if (start_go && state != S_RST_HOLD) begin
			next_state = S_RST_HOLD; // see [R18] [R20]
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// each state with a wait loads its count on entry
	assign tim_load = (next_state != state); // see [R24]

	always_comb begin
		tim_cnt = 32'h0000_0000;
		case (next_state)
			S_RST_HOLD: tim_cnt = PW_CYC;
			S_POST_RST: tim_cnt = POST_CYC;
			S_CLK_STB:  tim_cnt = CK_STB_CYC;
			S_CKE_XPR:  tim_cnt = {24'h00_0000, tim_a[TA_XPR+:8]};
			S_MRS_WAIT: tim_cnt = (mr_step == 3'h6) ? {24'h00_0000, tim_a[TA_MOD+:8]} :
			                      {24'h00_0000, tim_a[TA_MRD+:8]}; // see [R23]
			S_ZQ_WAIT:  tim_cnt = {16'h0000, zq_wait};
			S_RPR_WAIT: tim_cnt = {24'h00_0000, tim_a[TA_MOD+:8]};
			default:    tim_cnt = 32'h0000_0000;
		endcase
	end

	dri_wait_timer u_timer (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (tim_load),
		.count_i (tim_cnt),
		.done_o  (tim_done)
	);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mr_step <= 3'h0;
		end else if (next_state == S_CKE_XPR) begin
			mr_step <= 3'h0;
		end else if (state == S_MRS) begin
			mr_step <= mr_step + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control pins; odt is never used, so it stays low throughout
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reset_n_o   <= 1'b0;
			ck_en_o     <= 1'b0;
			cke_o       <= 1'b0;
			odt_o       <= 1'b0;
			init_done_o <= 1'b0;
		end else begin
			reset_n_o   <= !(next_state inside {S_IDLE, S_RST_HOLD});
			ck_en_o     <= !(next_state inside {S_IDLE, S_RST_HOLD, S_POST_RST});
			cke_o       <= !(next_state inside {S_IDLE, S_RST_HOLD, S_POST_RST,
			                                    S_CLK_STB}); // see [R6] [R18]
			odt_o       <= 1'b0; // see [R8]
			init_done_o <= next_state inside {S_READY, S_REPAIR, S_RPR_MR0,
			                                  S_RPR_WAIT}; // see [R25]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command bus: deselect unless a command is due
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd    <= CMD_DES;
			bg_o   <= 2'h0;
			ba_o   <= 2'h0;
			addr_o <= 18'h0_0000;
		end else begin
			cmd <= CMD_DES; // see [R5] [R13]
			if (next_state == S_MRS) begin
				cmd                <= CMD_MRS; // see [R22]
				{bg_o, ba_o}       <= {1'b0, mr_sel(mr_step)}; // see [R21] [R11]
				addr_o             <= mr_val[mr_sel(mr_step)];
			end else if (next_state == S_ZQCL) begin
				cmd    <= CMD_ZQCL; // see [R12]
				addr_o <= ZQ_ADDR;
			end else if (next_state == S_RPR_MR0) begin
				cmd          <= CMD_MRS; // see [R17]
				{bg_o, ba_o} <= 4'h0;
				addr_o       <= mr_val[0];
			end else if (state == S_READY && next_state == S_READY) begin
				if (ucmd_go) begin
					cmd    <= {1'b0, ucmd[CF_OP+:4]};
					bg_o   <= ucmd[CF_BG+:2];
					ba_o   <= ucmd[CF_BA+:2];
					addr_o <= ucmd[17:0];
				end else if (ref_pend) begin
					cmd <= CMD_REF; // see [R15]
				end
			end
		end
	end

	assign {cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} = cmd;

	dri_idle_keeper #(
		.PERIOD (KEEP_CYC)
	) u_keeper (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (init_done_o),
		.kick_i (!cs_n_o),
		.req_o  (ref_req)
	);

	// a refresh asked for during repair waits until the bus is free
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_pend <= 1'b0;
		end else if (ref_req) begin
			ref_pend <= 1'b1;
		end else if ((state == S_READY && next_state == S_READY && !ucmd_go) ||
		             !init_done_o) begin
			ref_pend <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	logic        is_mrs;
	logic        is_zqcl;
	logic [31:0] rel_cnt;
	logic [31:0] ck_cnt;
	logic [31:0] cke_cnt;
	logic [31:0] gap_cnt;
	logic [31:0] zq_cnt;
	logic [31:0] idle_cnt;
	logic        last_mrs;
	logic [2:0]  last_mr;
	logic        mr1_seen;

	assign is_mrs  = ({cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} == CMD_MRS);
	assign is_zqcl = ({cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} == CMD_ZQCL);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rel_cnt  <= 32'h0000_0000;
			ck_cnt   <= 32'h0000_0000;
			cke_cnt  <= 32'h0000_0000;
			gap_cnt  <= 32'h0000_0000;
			zq_cnt   <= 32'h0000_0000;
			idle_cnt <= 32'h0000_0000;
			last_mrs <= 1'b0;
			last_mr  <= 3'h0;
			mr1_seen <= 1'b0;
		end else begin
			rel_cnt  <= reset_n_o ? rel_cnt + 32'h0000_0001 : 32'h0000_0000;
			ck_cnt   <= ck_en_o ? ck_cnt + 32'h0000_0001 : 32'h0000_0000;
			cke_cnt  <= cke_o ? cke_cnt + 32'h0000_0001 : 32'h0000_0000;
			gap_cnt  <= !cs_n_o ? 32'h0000_0001 : gap_cnt + 32'h0000_0001;
			zq_cnt   <= is_zqcl ? 32'h0000_0001 : zq_cnt + 32'h0000_0001;
			idle_cnt <= (!cs_n_o || !init_done_o) ? 32'h0000_0000 :
			            idle_cnt + 32'h0000_0001;
			if (!cs_n_o) begin
				last_mrs <= is_mrs;
				last_mr  <= {bg_o[0], ba_o};
			end
			if (!cke_o) begin
				mr1_seen <= 1'b0;
			end else if (is_mrs && {bg_o[0], ba_o} == 3'h1) begin
				mr1_seen <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_mr0_out;
		is_mrs && {bg_o, ba_o} == 4'h0;
	endsequence

	sequence s_rpr_rewrite;
		s_mr0_out ##1 cs_n_o;
	endsequence

	chk_post_rst_wait: assert property ($rose(cke_o) |-> rel_cnt >= POST_CYC) // see [R1]
		else $error("cke rose before the post-reset wait");
	chk_clk_stable: assert property ($rose(cke_o) |-> ck_cnt >= CK_STB_CYC) // see [R4]
		else $error("cke rose before the clock was stable");
	chk_des_at_cke: assert property ($rose(cke_o) |-> cs_n_o) // see [R5]
		else $error("no deselect as cke rose");
	chk_cke_held: assert property ($fell(cke_o) |-> !reset_n_o) // see [R6] [R18]
		else $error("cke dropped without reset");
	chk_odt_static: assert property (cke_o && !init_done_o |-> !odt_o && $stable(odt_o)) // see [R8]
		else $error("odt moved during init");
	chk_xpr_wait: assert property (is_mrs && busy |-> cke_cnt > tim_a[TA_XPR+:8]) // see [R9]
		else $error("mrs too soon after cke");
	chk_mrs_spacing: assert property (!cs_n_o && last_mrs && busy |->
		gap_cnt > ((last_mr == 3'h0) ? tim_a[TA_MOD+:8] : tim_a[TA_MRD+:8])) // see [R10] [R23]
		else $error("command too soon after mrs");
	chk_dll_order: assert property (is_mrs && busy && last_mr != 3'h0 && {bg_o[0], ba_o} == 3'h0
		|-> mr1_seen) // see [R11]
		else $error("mr0 before mr1");
	chk_zq_after_mr0: assert property (is_zqcl && busy |-> last_mrs && last_mr == 3'h0) // see [R12]
		else $error("zq calibration not after mr0");
	chk_gap_deselect: assert property (busy && cke_o |-> cs_n_o || is_mrs || is_zqcl) // see [R13]
		else $error("stray command during init");
	chk_mr_select: assert property (is_mrs |-> !bg_o[1] && {bg_o[0], ba_o} != 3'h7) // see [R21]
		else $error("mrs to a bad register");
	chk_done_waits: assert property ($rose(init_done_o) |-> zq_cnt > zq_wait) // see [R25]
		else $error("done before final waits");
	chk_repair_mr0: assert property (state == S_REPAIR && alert_n_i |=> s_rpr_rewrite) // see [R17]
		else $error("mr0 not rewritten after repair");
	chk_keep_alive: assert property (init_done_o |-> idle_cnt <= KEEP_CYC + 3) // see [R15]
		else $error("idle too long without refresh");

endmodule

/* testbench/dri_dram_model.sv */
// dri_dram_model: behavioural dram on the host pins, counts host faults
// assumes one clock; a command is cs_n low while cke is high
`timescale 1ns/1ps
module dri_dram_model #(
	parameter int PW   = 125,
	parameter int POST = 50,
	parameter int XPR  = 45,
	parameter int MRD  = 8,
	parameter int MOD  = 24,
	parameter int ZQW  = 64,
	parameter int RPR  = 20
) (
	// pins
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ck_en_i,
	input  wire logic        cke_i,
	input  wire logic        odt_i,
	input  wire logic [4:0]  cmd_i,
	input  wire logic [3:0]  bank_i,
	input  wire logic [17:0] addr_i,
	output logic             alert_n_o,
	// observation
	output int               err_o,
	output int               mrs_n_o,
	output int               ref_n_o,
	output int               zq_age_o,
	output logic [17:0]      mr0_o
);
	int         rst_lo, cke_lo, post, ck_on, since_cke, since_mrs, idx, left;
	logic       arm, wait_mr0, mr1_dll, odt_hiz;
	logic [6:0] mask;
	int         ord [7] = '{3, 6, 5, 4, 2, 1, 0};

	assign odt_hiz = reset_n_i !== 1'b1 || since_cke < 0;

	task automatic bad(input string m);
		err_o++;
		$display("BAD %0t model: %s", $time, m);
	endtask

	task automatic mrs();
		int r;
		r = int'(bank_i[2:0]);
		if (bank_i[3] !== 1'b0 || r == 7) bad("mr select");
		if (since_mrs < MRD || since_cke < XPR) bad("mrs spacing");
		if (zq_age_o < 0 && (idx > 6 || r != ord[idx])) bad("mrs order");
		if (r == 0 && !mr1_dll) bad("dll order");
		if (r == 1) mr1_dll = addr_i[0];
		if (r == 4) arm = addr_i[0];
		if (r == 0 && wait_mr0) mr0_o = addr_i;
		if (r == 0 && !wait_mr0 && arm && zq_age_o >= ZQW) begin
			left = RPR;
			arm = 1'b0;
			alert_n_o <= 1'b0;
		end
		wait_mr0 = wait_mr0 && r != 0;
		mask[r] = 1'b1;
		idx++;
		mrs_n_o++;
		since_mrs = 0;
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (reset_n_i !== 1'b1) begin
			// refresh, mrs and error counts and the saved mr0 survive a reset, all else restarts
			rst_lo++;
			cke_lo = cke_i ? 0 : cke_lo + 1;
			post = 0;
			ck_on = 0;
			since_cke = -1;
			since_mrs = 1000;
			idx = 0;
			mask = '0;
			arm = 1'b0;
			wait_mr0 = 1'b0;
			mr1_dll = 1'b0;
			zq_age_o = -1;
			left = 0;
			alert_n_o <= 1'b1;
		end else begin
			if (post == 0 && (rst_lo < PW || cke_lo < 2)) bad("reset pulse");
			rst_lo = 0;
			post++;
			ck_on += int'(ck_en_i);
			since_mrs++;
			if (since_cke >= 0) since_cke++;
			if (zq_age_o >= 0) zq_age_o++;
			if (left == 1) begin
				alert_n_o <= 1'b1;
				wait_mr0 = 1'b1;
			end
			if (left > 0) left--;
			if (cke_i === 1'b1 && since_cke < 0) begin
				since_cke = 0;
				if (post < POST || ck_on < 5 || cmd_i !== 5'h1F) bad("cke rise");
			end
			if (since_cke >= 0 && zq_age_o < ZQW && {cke_i, odt_i} !== 2'b10) bad("cke/odt");
			if (cke_i === 1'b1 && cmd_i[4] === 1'b0) begin
				if (cmd_i === 5'h08) mrs();
				else if (since_mrs < MOD || wait_mr0 || !alert_n_o) bad("early cmd");
				else if (cmd_i === 5'h09 && zq_age_o >= ZQW) ref_n_o++;
				else if (cmd_i === 5'h0E && zq_age_o < 0 && mask == 7'h7F && addr_i[10]) begin
					zq_age_o = 0;
				end
				else bad("stray cmd");
			end
		end
	end
endmodule

/* testbench/test_dri_init_ctrl.sv */
// test_dri_init_ctrl: register-level bench of the dram init controller
// assumes dri_dram_model on the pins; long waits shortened by parameters
`timescale 1ns/1ps
module test_dri_init_ctrl import dri_pkg::*;;
	localparam int POST = 50;
	localparam int ZQW  = 64;
	logic        clk_i, rst_i, hsel, hwrite, hready, hresp, cke, odt, done;
	logic        reset_n, ck_en, cs_n, act_n, ras_n, cas_n, we_n, alert_n;
	logic [1:0]  htrans, bg, ba;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [17:0] addr, mr0;
	int          failures, n_tests, err, mrs_n, ref_n, zq_age, r0;

	dri_init_ctrl #(.POST_CYC(POST), .KEEP_CYC(200)) i_dri_init_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .reset_n_o(reset_n),
		.ck_en_o(ck_en), .cke_o(cke), .odt_o(odt), .cs_n_o(cs_n), .act_n_o(act_n),
		.ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .bg_o(bg), .ba_o(ba),
		.addr_o(addr), .alert_n_i(alert_n), .init_done_o(done));

	dri_dram_model #(.PW(PW_CYC), .POST(POST), .XPR(XPR_CYC), .MRD(TMRD_RST),
		.MOD(TMOD_RST), .ZQW(ZQW)) i_dri_dram_model (
		.clk_i(clk_i), .reset_n_i(reset_n), .ck_en_i(ck_en), .cke_i(cke), .odt_i(odt),
		.cmd_i({cs_n, act_n, ras_n, cas_n, we_n}), .bank_i({bg, ba}), .addr_i(addr),
		.alert_n_o(alert_n), .err_o(err), .mrs_n_o(mrs_n), .ref_n_o(ref_n),
		.zq_age_o(zq_age), .mr0_o(mr0));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d, failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic fail(input string m);
		failures++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
	endtask

	// one bounded wait per bus phase; the slave may stretch either
	task automatic rdy();
		int k;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (k >= 20) begin
			fail("bus hang");
			wrap_up();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'b10;
		rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wait_done(input int n);
		int k;
		k = 0;
		while (done !== 1'b1 && k < n) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= n) begin
			fail("init hang");
			wrap_up();
		end
	endtask

	function automatic logic [31:0] img(input int n);
		return (n == 0) ? 32'h0000_0100 : 32'(n * 16 + int'(n == 1));
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = '0;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc(A_TIMA, {8'h00, TXPR_RST, TMOD_RST, TMRD_RST});
		rdc(A_TIMB, {TZQI_RST, TDLLK_RST});
		rdc(A_STAT, 32'h0000_0004);
		rdc(8'h14, 32'h0000_0000);
		bus(1'b1, A_TIMA, 32'hFF2E_1909);
		rdc(A_TIMA, 32'h002E_1909);
		bus(1'b1, A_TIMA, {8'h00, TXPR_RST, TMOD_RST, TMRD_RST});
		bus(1'b1, A_TIMB, 32'h0040_0030);
		rdc(A_TIMB, 32'h0040_0030);
		for (int n = 0; n < 7; n++) bus(1'b1, A_MR0 + 8'(4 * n), img(n));
		rdc(A_MR0 + 8'h04, 32'h0000_0011);
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
		$display("registers done");
		// a command during init is refused and flagged
		bus(1'b1, A_CTRL, 32'h0000_0001);
		bus(1'b1, A_CMD, 32'h0200_0000);
		idle(3);
		rdc(A_STAT, 32'h0000_0016);
		bus(1'b1, A_STAT, 32'h0000_0010);
		rdc(A_STAT, 32'h0000_0006);
		wait_done(2000);
		chk(32'(mrs_n), 32'h0000_0007);
		chk(32'(zq_age >= ZQW), 32'h0000_0001);
		rdc(A_STAT, 32'h0000_0005);
		chk({30'h0, cke, odt}, 32'h0000_0002);
		$display("init done");
		r0 = ref_n;
		idle(260);
		chk(32'(ref_n - r0), 32'h0000_0001);
		$display("keepalive done");
		bus(1'b1, A_CMD, 32'h0210_0001);
		idle(40);
		bus(1'b1, A_CMD, 32'h0200_00AA);
		idle(4);
		bus(1'b0, A_STAT, 32'h0000_0000);
		chk(rd & 32'h0000_0004, 32'h0000_0000);
		idle(60);
		chk({14'h0, mr0}, 32'h0000_0100);
		chk(32'(mrs_n), 32'h0000_000A);
		rdc(A_STAT, 32'h0000_000D);
		bus(1'b1, A_STAT, 32'h0000_0008);
		rdc(A_STAT, 32'h0000_0005);
		$display("repair done");
		bus(1'b1, A_CTRL, 32'h0000_0001);
		idle(4);
		wait_done(2000);
		chk(32'(mrs_n), 32'h0000_0011);
		rdc(A_MR0, 32'h0000_0100);
		chk(32'(err), 32'h0000_0000);
		$display("restart done");
		wrap_up();
	end
endmodule
